// [plc_consts.svh]
`ifndef PLC_CONSTS_SVH
`define PLC_CONSTS_SVH
// ----------------------------------------
// widths and depths
// ----------------------------------------
`define PLC_QDEPTH 4
`define PLC_CFG_WORDS 8
`define PLC_PIN 12
`define PLC_PTERMS 8
`define PLC_POUTS 4
// ----------------------------------------
// configuration word fields
// ----------------------------------------
`define PLC_F_FUNC 2:0
`define PLC_F_ASEL 3
`define PLC_F_BSEL 5:4
`define PLC_F_A0WR 7:6
`define PLC_F_A1WR 9:8
`define PLC_F_D0LD 10
`define PLC_F_D1LD 11
`define PLC_F_Q0CAP 12
`define PLC_F_Q0SRC 13
`define PLC_F_Q1CAP 14
`define PLC_F_Q1SRC 15
// ----------------------------------------
// bus register selects
// ----------------------------------------
`define PLC_R_AC0 3'h0
`define PLC_R_AC1 3'h1
`define PLC_R_DR0 3'h2
`define PLC_R_DR1 3'h3
`define PLC_R_Q0 3'h4
`define PLC_R_Q1 3'h5
// ----------------------------------------
// configuration port regions and fields
// ----------------------------------------
`define PLC_CR_RAM 3'h0
`define PLC_CR_PLA0 3'h1
`define PLC_CR_PLA1 3'h2
`define PLC_CR_OR 3'h3
`define PLC_CA_REGION 6:4
`define PLC_CA_WORD 2:0
`define PLC_CA_COMP 3
`define PLC_CA_ORARR 2
`define PLC_CA_OROUT 1:0
`define PLC_CD_MASK 11:0
`define PLC_CD_OR 7:0
`define PLC_CD_REG 8
// ----------------------------------------
// reset values and constants
// ----------------------------------------
`define PLC_ZERO8 8'h00
`define PLC_ZERO12 12'h000
`define PLC_ZERO16 16'h0000
`define PLC_ONE8 8'h01
`endif

// [plc_pkg.sv]
package plc_pkg;
   // alu functions, selected per cycle by the active configuration word
   typedef enum logic [2:0] {
      PLC_FN_PASS, PLC_FN_INC, PLC_FN_DEC, PLC_FN_ADD,
      PLC_FN_SUB, PLC_FN_AND, PLC_FN_OR, PLC_FN_XOR
   } plc_alu_fn_t;
   // second operand source
   typedef enum logic [1:0] {
      PLC_B_DR0, PLC_B_DR1, PLC_B_AC0, PLC_B_AC1
   } plc_bsel_t;
   // accumulator write source
   typedef enum logic [1:0] {
      PLC_AW_HOLD, PLC_AW_ALU, PLC_AW_QUEUE
   } plc_accwr_t;
endpackage

// [plc_queue.sv]
`timescale 1ns/1ns
// ----------------------------------------
// small synchronous queue, fall-through head
// ----------------------------------------
module plc_queue #(
   parameter int W = 8,
   parameter int DEPTH = 4
) (
   input wire logic sys_clk_i,
   input wire logic reset_i,
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [W-1:0] in_data_i,
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [W-1:0] out_data_o,
   output logic full_o,
   output logic empty_o
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CW = $clog2(DEPTH + 1);
   localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
   localparam logic [CW-1:0] FULLC = CW'(DEPTH);

   logic [W-1:0] mem_q [DEPTH];
   logic [AW-1:0] wr_q;
   logic [AW-1:0] rd_q;
   logic [CW-1:0] cnt_q;
   logic push;
   logic pop;

   // handshakes; a full queue refuses, an empty one offers nothing
   assign full_o = (cnt_q == FULLC);
   assign empty_o = (cnt_q == '0);
   assign in_ready_o = ~full_o;
   assign out_valid_o = ~empty_o;
   assign out_data_o = mem_q[rd_q];
   assign push = in_valid_i & in_ready_o;
   assign pop = out_valid_o & out_ready_i;

   // storage, no reset needed since count guards reads
   always_ff @(posedge sys_clk_i) begin
      if (push) begin
         mem_q[wr_q] <= in_data_i;
      end
   end

   // pointers wrap explicitly so odd depths work too
   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         wr_q <= '0;
         rd_q <= '0;
      end else begin
         if (push) begin
            wr_q <= (wr_q == LAST) ? '0 : wr_q + AW'(1);
         end
         if (pop) begin
            rd_q <= (rd_q == LAST) ? '0 : rd_q + AW'(1);
         end
      end
   end

   // occupancy
   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         cnt_q <= '0;
      end else begin
         cnt_q <= cnt_q + CW'(push) - CW'(pop);
      end
   end
endmodule // plc_queue

// [plc_cell.sv]
`timescale 1ns/1ns
`include "plc_consts.svh"
// How it works
// - an 8-bit alu finishes each operation in one cycle, next to compare and condition logic.
// - the alu offers pass, increment, decrement, add, subtract, and, or and xor, no more.
// - two accumulators, two data registers and two queues all stay reachable from the bus.
// - each accumulator feeds the alu, takes its result and feeds the compare logic.
// - each data register feeds the alu and compares but is never written by the alu.
// - each queue talks to the bus, can load registers and can capture accumulator or alu data.
// - each queue holds at most four bytes.
// - eight 16-bit configuration words set the datapath function.
// - the active configuration word may change on every clock.
// - the configuration address comes from the routing side, which must drive it.
// - two logic arrays take routed inputs and give registered outputs, each optionally through an extra macrocell stage.
// - each array has twelve inputs feeding eight product terms.
// - each product term ands any of the inputs, true or complemented.
// - each output ors any of the eight terms, same width for every output.
// - firmware steers the cell with a run input and sees stall and queue status.
module plc_cell (
   input wire logic sys_clk_i,
   input wire logic reset_i,
   input wire logic run_i,
   input wire logic cfg_wr_i,
   input wire logic [6:0] cfg_addr_i,
   input wire logic [15:0] cfg_data_i,
   input wire logic bus_wr_i,
   input wire logic bus_rd_i,
   input wire logic [2:0] bus_sel_i,
   input wire logic [7:0] bus_wdata_i,
   output logic [7:0] bus_rdata_o,
   output logic bus_ack_o,
   output logic bus_err_o,
   input wire logic [2:0] seq_addr_i,
   input wire logic [11:0] route0_i,
   input wire logic [11:0] route1_i,
   output logic [3:0] array0_o,
   output logic [3:0] array1_o,
   output logic [7:0] alu_o,
   output logic [1:0] cmp_eq_o,
   output logic [1:0] cmp_lt_o,
   output logic [1:0] queue_full_o,
   output logic [1:0] queue_empty_o,
   output logic stall_o
);
   // ----------------------------------------
   // decode helpers
   // ----------------------------------------
   function automatic logic cfg_hit(input logic [6:0] a, input logic [2:0] region);
      cfg_hit = (a[`PLC_CA_REGION] == region);
   endfunction

   function automatic logic pterm(input logic [11:0] x, input logic [11:0] t,
                                  input logic [11:0] c);
      pterm = &((x | ~t) & (~x | ~c));
   endfunction

   // ----------------------------------------
   // state
   // ----------------------------------------
   logic [15:0] cfg_ram_q [`PLC_CFG_WORDS];
   logic [7:0] accumulator_q [2];
   logic [7:0] operand_register_q [2];
   logic [11:0] tmask_q [2][`PLC_PTERMS];
   logic [11:0] cmask_q [2][`PLC_PTERMS];
   logic [7:0] ormask_q [2][`PLC_POUTS];
   logic [3:0] regsel_q [2];
   logic [3:0] macro_q [2];
   logic [3:0] arr_out_q [2];
   logic [7:0] bus_rdata_q;
   logic bus_ack_q;
   logic bus_err_q;
   logic [7:0] alu_q;
   logic [1:0] cmp_eq_q;
   logic [1:0] cmp_lt_q;
   logic [1:0] qfull_q;
   logic [1:0] qempty_q;
   logic stall_q;

   // ----------------------------------------
   // combinational nets
   // ----------------------------------------
   logic [15:0] cur;
   plc_pkg::plc_alu_fn_t fn;
   plc_pkg::plc_bsel_t bsel;
   logic [1:0] awr [2];
   logic [7:0] src_a;
   logic [7:0] src_b;
   logic [7:0] alu_res;
   logic [1:0] need_ld;
   logic [1:0] need_cap;
   logic [1:0] q_full;
   logic [1:0] q_empty;
   logic [1:0] dp_push;
   logic [1:0] dp_pop;
   logic [1:0] bus_push;
   logic [1:0] bus_pop;
   logic [1:0] q_ready;
   logic [1:0] q_valid;
   logic [7:0] q_head [2];
   logic [7:0] cap_data [2];
   logic [11:0] pla_in [2];
   logic [7:0] terms [2];
   logic [3:0] sums [2];
   logic stall;
   logic advance;
   logic bus_wr;
   logic bus_rd;
   logic bad_sel;

   // ----------------------------------------
   // configuration selection
   // ----------------------------------------
   // address is sampled every cycle, so the routing side must hold it valid
   assign cur = cfg_ram_q[seq_addr_i];
   assign fn = plc_pkg::plc_alu_fn_t'(cur[`PLC_F_FUNC]);
   assign bsel = plc_pkg::plc_bsel_t'(cur[`PLC_F_BSEL]);
   assign awr[0] = cur[`PLC_F_A0WR];
   assign awr[1] = cur[`PLC_F_A1WR];

   // configuration ram writes
   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         for (int i = 0; i < `PLC_CFG_WORDS; i++) begin
            cfg_ram_q[i] <= `PLC_ZERO16;
         end
      end else if (cfg_wr_i && cfg_hit(cfg_addr_i, `PLC_CR_RAM)) begin
         cfg_ram_q[cfg_addr_i[`PLC_CA_WORD]] <= cfg_data_i;
      end
   end

   // ----------------------------------------
   // alu and operand muxes
   // ----------------------------------------
   assign src_a = cur[`PLC_F_ASEL] ? accumulator_q[1] : accumulator_q[0];

   // data registers and accumulators both usable as second operand
   always_comb begin
      src_b = operand_register_q[0];
      unique case (bsel)
         plc_pkg::PLC_B_DR0: src_b = operand_register_q[0];
         plc_pkg::PLC_B_DR1: src_b = operand_register_q[1];
         plc_pkg::PLC_B_AC0: src_b = accumulator_q[0];
         plc_pkg::PLC_B_AC1: src_b = accumulator_q[1];
      endcase
   end

   // single-cycle function, carry is dropped on purpose
   always_comb begin
      alu_res = src_a;
      unique case (fn)
         plc_pkg::PLC_FN_PASS: alu_res = src_a;
         plc_pkg::PLC_FN_INC: alu_res = src_a + `PLC_ONE8;
         plc_pkg::PLC_FN_DEC: alu_res = src_a - `PLC_ONE8;
         plc_pkg::PLC_FN_ADD: alu_res = src_a + src_b;
         plc_pkg::PLC_FN_SUB: alu_res = src_a - src_b;
         plc_pkg::PLC_FN_AND: alu_res = src_a & src_b;
         plc_pkg::PLC_FN_OR: alu_res = src_a | src_b;
         plc_pkg::PLC_FN_XOR: alu_res = src_a ^ src_b;
      endcase
   end

   // ----------------------------------------
   // queues
   // ----------------------------------------
   // the whole datapath waits rather than lose or invent a byte
   assign stall = |(need_ld & q_empty) | |(need_cap & q_full);
   assign advance = run_i & ~stall;
   assign bus_wr = bus_wr_i;
   assign bus_rd = bus_rd_i & ~bus_wr_i; // write wins a double request
   assign bad_sel = (bus_sel_i > `PLC_R_Q1);

   assign need_ld[0] = (awr[0] == plc_pkg::PLC_AW_QUEUE) | cur[`PLC_F_D0LD];
   assign need_ld[1] = (awr[1] == plc_pkg::PLC_AW_QUEUE) | cur[`PLC_F_D1LD];
   assign need_cap[0] = cur[`PLC_F_Q0CAP];
   assign need_cap[1] = cur[`PLC_F_Q1CAP];
   assign cap_data[0] = cur[`PLC_F_Q0SRC] ? alu_res : accumulator_q[0];
   assign cap_data[1] = cur[`PLC_F_Q1SRC] ? alu_res : accumulator_q[1];

   for (genvar i = 0; i < 2; i++) begin : g_queue
      logic [2:0] qsel;
      assign qsel = (i == 0) ? `PLC_R_Q0 : `PLC_R_Q1;
      assign dp_push[i] = need_cap[i] & advance;
      assign dp_pop[i] = need_ld[i] & advance;
      // datapath owns the port in a shared cycle; bus is refused
      assign bus_push[i] = bus_wr & (bus_sel_i == qsel) & q_ready[i] & ~dp_push[i];
      assign bus_pop[i] = bus_rd & (bus_sel_i == qsel) & q_valid[i] & ~dp_pop[i];

      plc_queue #(
         .W(8),
         .DEPTH(`PLC_QDEPTH)
      ) u_queue (
         .sys_clk_i(sys_clk_i),
         .reset_i(reset_i),
         .in_valid_i(dp_push[i] | bus_push[i]),
         .in_ready_o(q_ready[i]),
         .in_data_i(dp_push[i] ? cap_data[i] : bus_wdata_i),
         .out_valid_o(q_valid[i]),
         .out_ready_i(dp_pop[i] | bus_pop[i]),
         .out_data_o(q_head[i]),
         .full_o(q_full[i]),
         .empty_o(q_empty[i])
      );
   end

   // ----------------------------------------
   // working registers
   // ----------------------------------------
   for (genvar i = 0; i < 2; i++) begin : g_regs
      logic [2:0] asel;
      logic [2:0] dsel;
      logic dld;
      assign asel = (i == 0) ? `PLC_R_AC0 : `PLC_R_AC1;
      assign dsel = (i == 0) ? `PLC_R_DR0 : `PLC_R_DR1;
      assign dld = (i == 0) ? cur[`PLC_F_D0LD] : cur[`PLC_F_D1LD];

      // accumulator: firmware write has priority over the datapath
      always_ff @(posedge sys_clk_i) begin
         if (reset_i) begin
            accumulator_q[i] <= `PLC_ZERO8;
         end else if (bus_wr && bus_sel_i == asel) begin
            accumulator_q[i] <= bus_wdata_i;
         end else if (advance) begin
            unique case (awr[i])
               plc_pkg::PLC_AW_ALU: accumulator_q[i] <= alu_res;
               plc_pkg::PLC_AW_QUEUE: accumulator_q[i] <= q_head[i];
               default: accumulator_q[i] <= accumulator_q[i];
            endcase
         end
      end

      // data register: only firmware or its queue load it
      always_ff @(posedge sys_clk_i) begin
         if (reset_i) begin
            operand_register_q[i] <= `PLC_ZERO8;
         end else if (bus_wr && bus_sel_i == dsel) begin
            operand_register_q[i] <= bus_wdata_i;
         end else if (advance && dld) begin
            operand_register_q[i] <= q_head[i];
         end
      end

      // compare accumulator against its data register every cycle
      always_ff @(posedge sys_clk_i) begin
         if (reset_i) begin
            cmp_eq_q[i] <= 1'b0;
            cmp_lt_q[i] <= 1'b0;
         end else begin
            cmp_eq_q[i] <= (accumulator_q[i] == operand_register_q[i]);
            cmp_lt_q[i] <= (accumulator_q[i] < operand_register_q[i]);
         end
      end
   end

   // ----------------------------------------
   // bus answer
   // ----------------------------------------
   // one-cycle ack or err after each access; reads of queues pop them
   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         bus_rdata_q <= `PLC_ZERO8;
         bus_ack_q <= 1'b0;
         bus_err_q <= 1'b0;
      end else begin
         bus_ack_q <= 1'b0;
         bus_err_q <= 1'b0;
         if (bus_wr) begin
            if (bad_sel || (bus_sel_i >= `PLC_R_Q0 && !(|bus_push))) begin
               bus_err_q <= 1'b1;
            end else begin
               bus_ack_q <= 1'b1;
            end
         end else if (bus_rd) begin
            bus_rdata_q <= `PLC_ZERO8;
            if (bad_sel || (bus_sel_i >= `PLC_R_Q0 && !(|bus_pop))) begin
               bus_err_q <= 1'b1;
            end else begin
               bus_ack_q <= 1'b1;
               unique case (bus_sel_i)
                  `PLC_R_AC0: bus_rdata_q <= accumulator_q[0];
                  `PLC_R_AC1: bus_rdata_q <= accumulator_q[1];
                  `PLC_R_DR0: bus_rdata_q <= operand_register_q[0];
                  `PLC_R_DR1: bus_rdata_q <= operand_register_q[1];
                  `PLC_R_Q0: bus_rdata_q <= q_head[0];
                  default: bus_rdata_q <= q_head[1];
               endcase
            end
         end
      end
   end

   // status seen by firmware, one cycle behind the queues
   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         qfull_q <= 2'h0;
         qempty_q <= 2'h3;
         stall_q <= 1'b0;
         alu_q <= `PLC_ZERO8;
      end else begin
         qfull_q <= q_full;
         qempty_q <= q_empty;
         stall_q <= run_i & stall;
         alu_q <= alu_res;
      end
   end

   // ----------------------------------------
   // logic arrays
   // ----------------------------------------
   assign pla_in[0] = route0_i;
   assign pla_in[1] = route1_i;

   // array programming: true mask, complement mask, or-mask and register select
   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         for (int a = 0; a < 2; a++) begin
            for (int t = 0; t < `PLC_PTERMS; t++) begin
               tmask_q[a][t] <= `PLC_ZERO12;
               cmask_q[a][t] <= `PLC_ZERO12;
            end
            for (int o = 0; o < `PLC_POUTS; o++) begin
               ormask_q[a][o] <= `PLC_ZERO8;
            end
            regsel_q[a] <= 4'h0;
         end
      end else if (cfg_wr_i) begin
         for (int a = 0; a < 2; a++) begin
            if (cfg_hit(cfg_addr_i, (a == 0) ? `PLC_CR_PLA0 : `PLC_CR_PLA1)) begin
               if (cfg_addr_i[`PLC_CA_COMP]) begin
                  cmask_q[a][cfg_addr_i[`PLC_CA_WORD]] <= cfg_data_i[`PLC_CD_MASK];
               end else begin
                  tmask_q[a][cfg_addr_i[`PLC_CA_WORD]] <= cfg_data_i[`PLC_CD_MASK];
               end
            end
         end
         if (cfg_hit(cfg_addr_i, `PLC_CR_OR)) begin
            ormask_q[cfg_addr_i[`PLC_CA_ORARR]][cfg_addr_i[`PLC_CA_OROUT]] <=
               cfg_data_i[`PLC_CD_OR];
            regsel_q[cfg_addr_i[`PLC_CA_ORARR]][cfg_addr_i[`PLC_CA_OROUT]] <=
               cfg_data_i[`PLC_CD_REG];
         end
      end
   end

   // sum of products; an empty term mask gives a true term, an empty or-mask a zero
   for (genvar a = 0; a < 2; a++) begin : g_pla
      for (genvar t = 0; t < `PLC_PTERMS; t++) begin : g_term
         assign terms[a][t] = pterm(pla_in[a], tmask_q[a][t], cmask_q[a][t]);
      end
      for (genvar o = 0; o < `PLC_POUTS; o++) begin : g_out
         assign sums[a][o] = |(terms[a] & ormask_q[a][o]);
      end

      // registered mode adds a macrocell stage ahead of the output flop
      always_ff @(posedge sys_clk_i) begin
         if (reset_i) begin
            macro_q[a] <= 4'h0;
            arr_out_q[a] <= 4'h0;
         end else begin
            macro_q[a] <= sums[a];
            arr_out_q[a] <= (regsel_q[a] & macro_q[a]) | (~regsel_q[a] & sums[a]);
         end
      end
   end

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   assign bus_rdata_o = bus_rdata_q;
   assign bus_ack_o = bus_ack_q;
   assign bus_err_o = bus_err_q;
   assign alu_o = alu_q;
   assign cmp_eq_o = cmp_eq_q;
   assign cmp_lt_o = cmp_lt_q;
   assign queue_full_o = qfull_q;
   assign queue_empty_o = qempty_q;
   assign stall_o = stall_q;
   assign array0_o = arr_out_q[0];
   assign array1_o = arr_out_q[1];
endmodule // plc_cell

// [plc_cell_properties.sv]
`timescale 1ns/1ns
// ----------------------------------------
// port checks for the logic cell
// ----------------------------------------
module plc_cell_properties (
   input wire logic sys_clk_i,
   input wire logic reset_i,
   input wire logic run_i,
   input wire logic bus_wr_i,
   input wire logic bus_rd_i,
   input wire logic [2:0] bus_sel_i,
   input wire logic bus_ack_o,
   input wire logic bus_err_o,
   input wire logic [1:0] cmp_eq_o,
   input wire logic [1:0] cmp_lt_o,
   input wire logic [1:0] queue_full_o,
   input wire logic [1:0] queue_empty_o
);
   default clocking cb @(posedge sys_clk_i);
   endclocking
   default disable iff (reset_i);
   // a request and its single answer one cycle on
   sequence s_req;
      bus_wr_i || bus_rd_i;
   endsequence
   sequence s_ans;
      bus_ack_o != bus_err_o;
   endsequence
   property p_ans;
      s_req |=> s_ans;
   endproperty
   a_ans: assert property (p_ans) else $error("bus request not answered");
   property p_unmap;
      (bus_wr_i || bus_rd_i) && bus_sel_i[2:1] == 2'h3 |=> bus_err_o;
   endproperty
   a_unmap: assert property (p_unmap) else $error("unmapped access taken");
   property p_rst;
      $fell(reset_i) |-> queue_empty_o == 2'h3 && queue_full_o == 2'h0 && !bus_ack_o;
   endproperty
   a_rst: assert property (p_rst) else $error("bad state after reset");
   property p_flags;
      (queue_full_o & queue_empty_o) == 2'h0;
   endproperty
   a_flags: assert property (p_flags) else $error("queue full and empty");
   property p_cmp;
      (cmp_eq_o & cmp_lt_o) == 2'h0;
   endproperty
   a_cmp: assert property (p_cmp) else $error("equal and less at once");
   // flags lag a cycle, so only trust them when nothing moved last cycle
   property p_rd_empty;
      bus_rd_i && !bus_wr_i && bus_sel_i == 3'h4 && queue_empty_o[0] && !run_i
         && !$past(run_i) && !$past(bus_wr_i) |=> bus_err_o;
   endproperty
   a_rd_empty: assert property (p_rd_empty) else $error("empty read taken");
   property p_wr_full;
      bus_wr_i && bus_sel_i == 3'h4 && queue_full_o[0] && !run_i
         && !$past(run_i) && !$past(bus_rd_i) |=> bus_err_o;
   endproperty
   a_wr_full: assert property (p_wr_full) else $error("full write taken");
   // idle cell keeps its compare results
   property p_cmp_hold;
      !$past(run_i, 2) && !$past(bus_wr_i, 2)
         && !$past(reset_i) && !$past(reset_i, 2) |-> $stable(cmp_eq_o) && $stable(cmp_lt_o);
   endproperty
   a_cmp_hold: assert property (p_cmp_hold) else $error("compare moved while idle");
endmodule // plc_cell_properties

bind plc_cell plc_cell_properties u_props (
   .sys_clk_i(sys_clk_i),
   .reset_i(reset_i),
   .run_i(run_i),
   .bus_wr_i(bus_wr_i),
   .bus_rd_i(bus_rd_i),
   .bus_sel_i(bus_sel_i),
   .bus_ack_o(bus_ack_o),
   .bus_err_o(bus_err_o),
   .cmp_eq_o(cmp_eq_o),
   .cmp_lt_o(cmp_lt_o),
   .queue_full_o(queue_full_o),
   .queue_empty_o(queue_empty_o)
);

// [plc_fw_model.sv]
`timescale 1ns/1ns
// ----------------------------------------
// firmware side of the system bus
// ----------------------------------------
module plc_fw_model (
   input wire logic sys_clk_i,
   output logic bus_wr_o,
   output logic bus_rd_o,
   output logic [2:0] bus_sel_o,
   output logic [7:0] bus_wdata_o,
   input wire logic [7:0] bus_rdata_i,
   input wire logic bus_ack_i,
   input wire logic bus_err_i
);
   // idle bus at time zero
   initial begin
      bus_wr_o = 1'b0;
      bus_rd_o = 1'b0;
      bus_sel_o = 3'h0;
      bus_wdata_o = 8'h00;
   end
   // one-cycle strobe: holding it longer would issue a second access
   task automatic access(input logic wr, input logic [2:0] sel, input logic [7:0] wd,
                         output logic [7:0] rd, output logic ack, output logic err);
      @(posedge sys_clk_i);
      bus_wr_o <= wr;
      bus_rd_o <= !wr;
      bus_sel_o <= sel;
      bus_wdata_o <= wd;
      @(posedge sys_clk_i);
      bus_wr_o <= 1'b0;
      bus_rd_o <= 1'b0;
      bus_wdata_o <= ~wd; // stale data never looks valid
      #1;
      rd = bus_rdata_i;
      ack = bus_ack_i;
      err = bus_err_i;
   endtask
endmodule // plc_fw_model

// [plc_cell_tb.sv]
`timescale 1ns/1ns
module plc_cell_tb;
   logic clk, rst, run, cfg_wr, bwr, brd, ack, err, stall;
   logic [6:0] cfg_addr;
   logic [15:0] cfg_data;
   logic [2:0] seq, bsel;
   logic [11:0] r0, r1;
   logic [7:0] bwd, rdat, alu, v;
   logic [3:0] ar0, ar1;
   logic [1:0] eq, lt, full, empty;
   int err_total, checks;
   plc_cell u_dut (.sys_clk_i(clk), .reset_i(rst), .run_i(run), .cfg_wr_i(cfg_wr),
      .cfg_addr_i(cfg_addr), .cfg_data_i(cfg_data), .bus_wr_i(bwr), .bus_rd_i(brd),
      .bus_sel_i(bsel), .bus_wdata_i(bwd), .bus_rdata_o(rdat), .bus_ack_o(ack),
      .bus_err_o(err), .seq_addr_i(seq), .route0_i(r0), .route1_i(r1), .array0_o(ar0),
      .array1_o(ar1), .alu_o(alu), .cmp_eq_o(eq), .cmp_lt_o(lt), .queue_full_o(full),
      .queue_empty_o(empty), .stall_o(stall));
   plc_fw_model u_fw (.sys_clk_i(clk), .bus_wr_o(bwr), .bus_rd_o(brd), .bus_sel_o(bsel),
      .bus_wdata_o(bwd), .bus_rdata_i(rdat), .bus_ack_i(ack), .bus_err_i(err));
   // 125 MHz clock
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   // ----------------------------------------
   // helpers
   // ----------------------------------------
   task automatic conclude;
      $display("comparisons %0d mismatches %0d", checks, err_total);
      if (err_total == 0 && checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
      checks++;
      if (got !== exp) begin
         err_total++;
         $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   task automatic bus(input logic wr, input logic [2:0] sel, input logic [7:0] wd,
                      input logic xerr, output logic [7:0] rd);
      logic a, e;
      u_fw.access(wr, sel, wd, rd, a, e);
      chk({6'h00, a, e}, {6'h00, !xerr, xerr}, "bus answer");
   endtask
   task automatic cfg(input logic [6:0] a, input logic [15:0] d);
      @(posedge clk);
      cfg_wr <= 1'b1;
      cfg_addr <= a;
      cfg_data <= d;
      @(posedge clk);
      cfg_wr <= 1'b0;
   endtask
   function automatic logic [7:0] model(input int fn, input logic [7:0] a, input logic [7:0] b);
      case (fn)
         0: return a;
         1: return a + 8'h01;
         2: return a - 8'h01;
         3: return a + b;
         4: return a - b;
         5: return a & b;
         6: return a | b;
         default: return a ^ b;
      endcase
   endfunction
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic t_regs;
      for (int i = 0; i < 4; i++) bus(1'b1, 3'(i), 8'h5A ^ 8'(i), 1'b0, v);
      for (int i = 0; i < 4; i++) begin
         bus(1'b0, 3'(i), 8'h00, 1'b0, v);
         chk(v, 8'h5A ^ 8'(i), "register readback");
      end
      for (int i = 6; i < 8; i++) bus(1'b1, 3'(i), 8'h00, 1'b1, v);
      for (int i = 6; i < 8; i++) bus(1'b0, 3'(i), 8'h00, 1'b1, v);
   endtask
   task automatic t_alu;
      for (int fn = 0; fn < 8; fn++) begin
         bus(1'b1, 3'h0, 8'hFF, 1'b0, v);
         bus(1'b1, 3'h2, 8'h3A, 1'b0, v);
         cfg(7'h00, 16'h0040 | 16'(fn));
         @(posedge clk);
         seq <= 3'h0;
         run <= 1'b1;
         @(posedge clk);
         run <= 1'b0;
         #1 chk(alu, model(fn, 8'hFF, 8'h3A), "alu output");
         bus(1'b0, 3'h0, 8'h00, 1'b0, v);
         chk(v, model(fn, 8'hFF, 8'h3A), "alu result in acc0");
         bus(1'b0, 3'h2, 8'h00, 1'b0, v);
         chk(v, 8'h3A, "data0 untouched");
      end
   endtask
   task automatic t_queue;
      for (int q = 0; q < 2; q++) begin
         for (int i = 0; i < 4; i++) bus(1'b1, 3'(4 + q), 8'h11 * 8'(i + 1), 1'b0, v);
         bus(1'b1, 3'(4 + q), 8'hEE, 1'b1, v);
         chk({7'h00, full[q]}, 8'h01, "full flag");
         for (int i = 0; i < 4; i++) begin
            bus(1'b0, 3'(4 + q), 8'h00, 1'b0, v);
            chk(v, 8'h11 * 8'(i + 1), "queue order");
         end
         bus(1'b0, 3'(4 + q), 8'h00, 1'b1, v);
         chk({7'h00, empty[q]}, 8'h01, "empty flag");
      end
   endtask
   task automatic t_cmp;
      for (int i = 0; i < 2; i++) begin
         bus(1'b1, 3'(i), 8'h10, 1'b0, v);
         bus(1'b1, 3'(2 + i), 8'h20, 1'b0, v);
         repeat (2) @(posedge clk);
         chk({6'h00, eq[i], lt[i]}, 8'h01, "acc below data");
         bus(1'b1, 3'(i), 8'h20, 1'b0, v);
         repeat (2) @(posedge clk);
         chk({6'h00, eq[i], lt[i]}, 8'h02, "acc equals data");
      end
   endtask
   task automatic t_seq;
      cfg(7'h01, 16'hC041); // inc acc0, push the alu result into queue1
      cfg(7'h02, 16'h0200); // acc1 takes the queue1 head
      bus(1'b1, 3'h0, 8'h7F, 1'b0, v);
      @(posedge clk);
      seq <= 3'h1;
      run <= 1'b1;
      @(posedge clk);
      seq <= 3'h2;
      repeat (3) @(posedge clk);
      run <= 1'b0;
      chk({7'h00, stall}, 8'h01, "stall");
      bus(1'b0, 3'h1, 8'h00, 1'b0, v);
      chk(v, 8'h80, "acc1 loaded via queue");
      bus(1'b0, 3'h5, 8'h00, 1'b1, v);
   endtask
   task automatic t_array;
      for (int p = 0; p < 2; p++) begin
         cfg({3'(p + 1), 4'h0}, 16'h0801);
         cfg({3'(p + 1), 4'h8}, 16'h0020);
         cfg({3'h3, 1'b0, 1'(p), 2'h0}, 16'h0001);
         cfg({3'h3, 1'b0, 1'(p), 2'h1}, 16'h0101);
         for (int k = 0; k < 3; k++) begin
            @(posedge clk);
            if (p == 0) r0 <= (k == 0) ? 12'h801 : (k == 1) ? 12'h821 : 12'h800;
            else r1 <= (k == 0) ? 12'h801 : (k == 1) ? 12'h821 : 12'h800;
            repeat (3) @(posedge clk);
            chk({4'h0, (p == 0) ? ar0 : ar1}, (k == 0) ? 8'h03 : 8'h00, "array out");
         end
      end
   endtask
   // ----------------------------------------
   // main sequence and watchdog
   // ----------------------------------------
   initial begin
      rst = 1'b1;
      run = 1'b0;
      cfg_wr = 1'b0;
      cfg_addr = 7'h00;
      cfg_data = 16'h0000;
      seq = 3'h0;
      r0 = 12'h000;
      r1 = 12'h000;
      err_total = 0;
      checks = 0;
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      #1;
      chk({full, empty, stall, ack, err, 1'b0}, 8'h30, "reset state");
      t_regs();
      t_alu();
      t_queue();
      t_cmp();
      t_seq();
      t_array();
      conclude();
   end
   initial begin
      repeat (20000) @(posedge clk);
      err_total++;
      $display("[ERR] %0t run did not finish", $time);
      conclude();
   end
endmodule // plc_cell_tb
